// ### dtc_pin_model.sv
// Pin-side partner of the dual timer: drives pulse bursts on the count pins.
// Assumes ref_clk is the block clock and the bench spaces its burst requests.
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic go,
  input wire logic wide,
  input wire logic [3:0] len,
  input wire logic [3:0] gap,
  input wire logic pin_a,
  input wire logic pin_a_on,
  input wire logic pin_b,
  input wire logic pin_b_on,
  output logic narrow_count_pin,
  output logic wide_count_pin,
  output logic busy,
  output logic line_a,
  output logic line_b
);
  logic [4:0] edges;
  logic [3:0] hold;
  logic sel_wide;
  // A detached compare pin floats to its pull-up, so stale levels never pass.
  assign line_a = pin_a_on ? pin_a : 1'b1;
  assign line_b = pin_b_on ? pin_b : 1'b1;
  assign busy = (edges != 5'h00);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      edges <= 5'h00;
      hold <= 4'h0;
      sel_wide <= 1'b0;
      narrow_count_pin <= 1'b0;
      wide_count_pin <= 1'b0;
    end else if (go && edges == 5'h00) begin
      edges <= {len, 1'b0};
      hold <= gap;
      sel_wide <= wide;
    end else if (edges != 5'h00) begin
      // Each level is held gap+1 cycles, so a gap of zero gives one-cycle levels.
      if (hold != 4'h0) begin
        hold <= hold - 4'h1;
      end else begin
        edges <= edges - 5'h01;
        hold <= gap;
        if (sel_wide) begin
          wide_count_pin <= ~wide_count_pin;
        end else begin
          narrow_count_pin <= ~narrow_count_pin;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### dtc_pkg.sv
// Constants, register map and shared decode for the dual timer/counter block.
// Assumes a classic Wishbone master with 32-bit data and word-aligned registers.
package dtc_pkg;
  localparam int PRESCALE_W = 10;
  localparam logic [5:0] IDX_WIDE_CTL_A = 6'h2F;
  localparam logic [5:0] IDX_WIDE_CTL_B = 6'h2E;
  localparam logic [5:0] IDX_WIDE_COUNT = 6'h2C;
  localparam logic [5:0] IDX_CMP_A = 6'h2A;
  localparam logic [5:0] IDX_CMP_B = 6'h28;
  localparam logic [5:0] IDX_CAPTURE = 6'h24;
  localparam logic [5:0] IDX_NARROW_CTL = 6'h33;
  localparam logic [5:0] IDX_NARROW_COUNT = 6'h32;
  localparam logic [5:0] IDX_FLAGS = 6'h38;
  localparam logic [5:0] IDX_MASK = 6'h39;
  localparam logic [5:0] IDX_CMP_CFG = 6'h08;
  localparam int CTA_MODE_A_LSB = 6;
  localparam int CTA_MODE_B_LSB = 4;
  localparam int CTB_FILTER = 7;
  localparam int CTB_EDGE = 6;
  localparam int CTB_CLEAR = 3;
  localparam int FLG_OVF1 = 7;
  localparam int FLG_CMPA = 6;
  localparam int FLG_CMPB = 5;
  localparam int FLG_CAPT = 3;
  localparam int FLG_OVF0 = 1;
  localparam int CFG_CMP_SEL = 0;
  localparam logic [7:0] CTA_WMASK = 8'hF3;
  localparam logic [7:0] CTB_WMASK = 8'hCF;
  localparam logic [7:0] NARROW_CTL_WMASK = 8'h07;
  localparam logic [7:0] FLAG_USED = 8'hEA;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_CK = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR = 2'h2;
  localparam logic [1:0] OM_SET = 2'h3;
  localparam logic [1:0] PWM_OFF = 2'h0;
  localparam logic [1:0] PWM_8 = 2'h1;
  localparam logic [1:0] PWM_9 = 2'h2;
  localparam logic [15:0] TOP_8 = 16'h00FF;
  localparam logic [15:0] TOP_9 = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;

  // Taps fire when the low prescaler bits are all ones, so both counters see the same phase.
  function automatic logic clk_tick(input logic [2:0] cs, input logic [PRESCALE_W-1:0] pre,
                                    input logic fall, input logic rise);
    case (cs)
      CS_STOP: clk_tick = 1'b0;
      CS_CK: clk_tick = 1'b1;
      CS_DIV8: clk_tick = &pre[2:0];
      CS_DIV64: clk_tick = &pre[5:0];
      CS_DIV256: clk_tick = &pre[7:0];
      CS_DIV1024: clk_tick = &pre;
      CS_EXT_FALL: clk_tick = fall;
      default: clk_tick = rise;
    endcase
  endfunction

  function automatic logic [15:0] pwm_top(input logic [1:0] sel);
    case (sel)
      PWM_8: pwm_top = TOP_8;
      PWM_9: pwm_top = TOP_9;
      default: pwm_top = TOP_10;
    endcase
  endfunction
endpackage

// ### dtc_timer.sv
// Dual timer/counter: shared prescaler, 8-bit up counter, 16-bit counter with
// two compare channels, clear on match, input capture and centered PWM.
// Assumes a classic Wishbone master and pins synchronous or slow against ref_clk.
`timescale 1ns/1ps
`default_nettype none
module dtc_timer #(
  parameter int WB_ADR_W = 8,
  parameter int NOISE_SAMPLES = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic narrow_count_pin,
  input wire logic wide_count_pin,
  input wire logic capture_pin,
  input wire logic comparator_output,
  input wire logic [7:0] vector_ack,
  output logic [7:0] timer_irq_req,
  output logic compare_out_pin_a,
  output logic compare_out_pin_a_connected,
  output logic compare_out_pin_b,
  output logic compare_out_pin_b_connected
);
  import dtc_pkg::*;

  if (WB_ADR_W < 8) begin : g_bad_adr
    $error("WB_ADR_W must be at least 8");
  end
  if (NOISE_SAMPLES < 2 || NOISE_SAMPLES > 8) begin : g_bad_filter
    $error("NOISE_SAMPLES must lie between 2 and 8");
  end

  typedef struct packed {
    logic [PRESCALE_W-1:0] pre;
    logic [2:0] cs0;
    logic [7:0] cnt0;
    logic [7:0] ctla;
    logic [7:0] ctlb;
    logic [15:0] cnt1;
    logic [15:0] ocra;
    logic [15:0] ocrb;
    logic [15:0] ocra_buf;
    logic [15:0] ocrb_buf;
    logic [15:0] icr;
    logic dir_down;
    logic last_down;
    logic counted1;
    logic [7:0] flags;
    logic [7:0] mask;
    logic cmp_sel;
    logic [2:0] t0_sync;
    logic [2:0] t1_sync;
    logic [1:0] cap_sync;
    logic [NOISE_SAMPLES-1:0] cap_hist;
    logic cap_level;
    logic out_a;
    logic out_b;
    logic ack;
    logic [31:0] dat;
  } dtc_state_t;

  dtc_state_t st;
  dtc_state_t next_st;

  logic [5:0] idx;
  logic wr;
  logic narrow_wr;
  logic wide_wr;
  logic pwm_on;
  logic [15:0] top;
  logic tick0;
  logic tick1;
  logic match_a;
  logic match_b;
  logic cap_evt;
  logic [7:0] set_flags;
  logic [7:0] clr_flags;
  logic [31:0] rd_word;
  logic new_level;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d,
                                          input logic [1:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  // In PWM the counter direction decides the level, so an update never makes a narrow spike.
  function automatic logic pin_next(input logic [1:0] mode, input logic cur, input logic pwm,
                                    input logic down);
    if (pwm) begin
      case (mode)
        OM_CLEAR: pin_next = down;
        OM_SET: pin_next = ~down;
        default: pin_next = cur;
      endcase
    end else begin
      case (mode)
        OM_TOGGLE: pin_next = ~cur;
        OM_CLEAR: pin_next = 1'b0;
        OM_SET: pin_next = 1'b1;
        default: pin_next = cur;
      endcase
    end
  endfunction

  assign idx = wb_adr_i[7:2];
  assign wr = st.ack && wb_cyc_i && wb_stb_i && wb_we_i;
  assign narrow_wr = wr && idx == IDX_NARROW_COUNT && wb_sel_i[0];
  assign wide_wr = wr && idx == IDX_WIDE_COUNT && |wb_sel_i[1:0];
  assign pwm_on = st.ctla[1:0] != PWM_OFF;
  assign top = pwm_top(st.ctla[1:0]);
  // Both counters take their taps from the one prescaler.
  assign tick0 = clk_tick(st.cs0, st.pre, st.t0_sync[2] & ~st.t0_sync[1], ~st.t0_sync[2] & st.t0_sync[1]);
  assign tick1 = clk_tick(st.ctlb[2:0], st.pre, st.t1_sync[2] & ~st.t1_sync[1],
                          ~st.t1_sync[2] & st.t1_sync[1]);
  // A match only counts after the counter itself advanced, never after a software load.
  assign match_a = st.counted1 && st.cnt1 == (pwm_on ? st.ocra_buf : st.ocra);
  assign match_b = st.counted1 && st.cnt1 == (pwm_on ? st.ocrb_buf : st.ocrb);
  assign cap_evt = (new_level != st.cap_level) && (new_level == st.ctlb[CTB_EDGE]);

  always_comb begin
    next_st = st;
    set_flags = RST_BYTE;
    clr_flags = RST_BYTE;
    rd_word = 32'h0000_0000;
    next_st.pre = st.pre + 10'h001;
    // The edge detectors look only at the second and third stages.
    next_st.t0_sync = {st.t0_sync[1:0], narrow_count_pin};
    next_st.t1_sync = {st.t1_sync[1:0], wide_count_pin};
    next_st.cap_sync = {st.cap_sync[0], st.cmp_sel ? comparator_output : capture_pin};
    next_st.cap_hist = {st.cap_hist[NOISE_SAMPLES-2:0], st.cap_sync[1]};
    // Without the filter a single sample moves the trigger level.
    if (!st.ctlb[CTB_FILTER]) begin
      new_level = st.cap_sync[1];
    end else if (&next_st.cap_hist) begin
      new_level = 1'b1;
    end else if (~|next_st.cap_hist) begin
      new_level = 1'b0;
    end else begin
      new_level = st.cap_level;
    end
    next_st.cap_level = new_level;
    if (cap_evt) begin
      next_st.icr = st.cnt1;
      set_flags[FLG_CAPT] = 1'b1;
    end

    // Narrow counter: a write wins over a tick in the same cycle.
    if (narrow_wr) begin
      next_st.cnt0 = wb_dat_i[7:0];
    end else if (tick0) begin
      next_st.cnt0 = st.cnt0 + 8'h01;
      if (st.cnt0 == 8'hFF) begin
        set_flags[FLG_OVF0] = 1'b1;
      end
    end

    // Wide counter.
    next_st.counted1 = 1'b0;
    if (!pwm_on) begin
      next_st.ocra_buf = st.ocra;
      next_st.ocrb_buf = st.ocrb;
    end
    if (wide_wr) begin
      next_st.cnt1 = merge16(st.cnt1, wb_dat_i[15:0], wb_sel_i[1:0]);
    end else if (match_a && st.ctlb[CTB_CLEAR] && !pwm_on) begin
      // Clearing takes the cycle after the match, so the top value lasts one cycle even with slow taps.
      next_st.cnt1 = RST_WORD;
    end else if (tick1) begin
      next_st.counted1 = 1'b1;
      if (!pwm_on) begin
        next_st.cnt1 = st.cnt1 + 16'h0001;
        next_st.last_down = 1'b0;
        if (st.cnt1 == 16'hFFFF) begin
          set_flags[FLG_OVF1] = 1'b1;
        end
      end else if (st.dir_down) begin
        next_st.last_down = 1'b1;
        if (st.cnt1 <= 16'h0001) begin
          next_st.cnt1 = RST_WORD;
          next_st.dir_down = 1'b0;
          set_flags[FLG_OVF1] = 1'b1;
        end else begin
          next_st.cnt1 = st.cnt1 - 16'h0001;
        end
      end else begin
        next_st.last_down = 1'b0;
        if (st.cnt1 >= top - 16'h0001) begin
          // Compare values are taken only at the top, which keeps each period whole.
          next_st.cnt1 = top;
          next_st.dir_down = 1'b1;
          next_st.ocra_buf = st.ocra;
          next_st.ocrb_buf = st.ocrb;
        end else begin
          next_st.cnt1 = st.cnt1 + 16'h0001;
        end
      end
    end
    if (!pwm_on) begin
      next_st.dir_down = 1'b0;
    end
    if (match_a) begin
      set_flags[FLG_CMPA] = 1'b1;
      next_st.out_a = pin_next(st.ctla[7:6], st.out_a, pwm_on, st.last_down);
    end
    if (match_b) begin
      set_flags[FLG_CMPB] = 1'b1;
      next_st.out_b = pin_next(st.ctla[5:4], st.out_b, pwm_on, st.last_down);
    end

    // Register writes take effect at the edge where ack is seen.
    if (wr) begin
      case (idx)
        IDX_WIDE_CTL_A: if (wb_sel_i[0]) next_st.ctla = wb_dat_i[7:0] & CTA_WMASK;
        IDX_WIDE_CTL_B: if (wb_sel_i[0]) next_st.ctlb = wb_dat_i[7:0] & CTB_WMASK;
        IDX_NARROW_CTL: if (wb_sel_i[0]) next_st.cs0 = wb_dat_i[2:0];
        IDX_CMP_A: next_st.ocra = merge16(st.ocra, wb_dat_i[15:0], wb_sel_i[1:0]);
        IDX_CMP_B: next_st.ocrb = merge16(st.ocrb, wb_dat_i[15:0], wb_sel_i[1:0]);
        IDX_FLAGS: if (wb_sel_i[0]) clr_flags = wb_dat_i[7:0];
        IDX_MASK: if (wb_sel_i[0]) next_st.mask = wb_dat_i[7:0] & FLAG_USED;
        IDX_CMP_CFG: if (wb_sel_i[0]) next_st.cmp_sel = wb_dat_i[CFG_CMP_SEL];
        default: next_st.cmp_sel = st.cmp_sel;
      endcase
    end
    // A flag set in the cycle it is cleared survives.
    next_st.flags = ((st.flags & ~clr_flags & ~vector_ack) | set_flags) & FLAG_USED;

    case (idx)
      IDX_WIDE_CTL_A: rd_word = {24'h000000, st.ctla};
      IDX_WIDE_CTL_B: rd_word = {24'h000000, st.ctlb};
      IDX_WIDE_COUNT: rd_word = {16'h0000, st.cnt1};
      IDX_CMP_A: rd_word = {16'h0000, st.ocra};
      IDX_CMP_B: rd_word = {16'h0000, st.ocrb};
      IDX_CAPTURE: rd_word = {16'h0000, st.icr};
      IDX_NARROW_CTL: rd_word = {29'h00000000, st.cs0};
      IDX_NARROW_COUNT: rd_word = {24'h000000, st.cnt0};
      IDX_FLAGS: rd_word = {24'h000000, st.flags};
      IDX_MASK: rd_word = {24'h000000, st.mask};
      IDX_CMP_CFG: rd_word = {31'h00000000, st.cmp_sel};
      default: rd_word = 32'h0000_0000;
    endcase
    next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
    next_st.dat = next_st.ack ? rd_word : 32'h0000_0000;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.dat;
  assign timer_irq_req = st.flags & st.mask;
  assign compare_out_pin_a = st.out_a;
  assign compare_out_pin_b = st.out_b;
  // In PWM the toggle code has no meaning, so the pin is released.
  assign compare_out_pin_a_connected = pwm_on ? st.ctla[7] : (st.ctla[7:6] != OM_OFF);
  assign compare_out_pin_b_connected = pwm_on ? st.ctla[5] : (st.ctla[5:4] != OM_OFF);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_narrow_wrap: assert property (tick0 && !narrow_wr && st.cnt0 == 8'hFF
    |=> st.cnt0 == 8'h00 && st.flags[FLG_OVF0])
    else $error("Narrow counter did not wrap and flag.");
  a_narrow_stop: assert property (st.cs0 == CS_STOP && !narrow_wr |=> $stable(st.cnt0))
    else $error("Stopped narrow counter moved.");
  a_narrow_load: assert property (narrow_wr |=> st.cnt0 == $past(wb_dat_i[7:0]))
    else $error("Narrow counter did not take written value.");
  a_ext_rise_count: assert property (st.cs0 == 3'h7 && st.t0_sync[1] && !st.t0_sync[2] && !narrow_wr
    |=> st.cnt0 == $past(st.cnt0) + 8'h01)
    else $error("Rising pin edge not counted.");
  a_tap_1024: assert property (st.ctlb[2:0] == CS_DIV1024 && tick1 |=> st.pre == 10'h000)
    else $error("Divide by 1024 tap off phase.");
  a_clear_on_match: assert property (match_a && st.ctlb[CTB_CLEAR] && !pwm_on && !wide_wr
    |=> st.cnt1 == 16'h0000 && st.flags[FLG_CMPA])
    else $error("Counter not cleared on match A.");
  a_pin_set: assert property (match_a && !pwm_on && st.ctla[7:6] == OM_SET
    |=> compare_out_pin_a)
    else $error("Pin A not set on match.");
  a_pin_toggle: assert property (match_b && !pwm_on && st.ctla[5:4] == OM_TOGGLE
    |=> compare_out_pin_b != $past(compare_out_pin_b))
    else $error("Pin B not toggled on match.");
  a_capture_copy: assert property (cap_evt |=> st.icr == $past(st.cnt1) && st.flags[FLG_CAPT])
    else $error("Capture did not copy count.");
  a_filter_agree: assert property (cap_evt && st.ctlb[CTB_FILTER]
    |=> (&st.cap_hist) || (~|st.cap_hist))
    else $error("Filtered capture without agreeing samples.");
  a_pwm_bound: assert property (pwm_on && !wr && st.cnt1 <= top
    |=> st.cnt1 <= pwm_top($past(st.ctla[1:0])))
    else $error("PWM count left its range.");
  a_ctl_reserved: assert property (wb_ack_o && !wb_we_i && idx == IDX_WIDE_CTL_A
    |-> wb_dat_o[3:2] == 2'h0 && wb_dat_o[31:8] == 24'h000000)
    else $error("Reserved control bits read nonzero.");

  c_narrow_wrap: cover property (tick0 && st.cnt0 == 8'hFF);
  c_capture: cover property (cap_evt);
  c_pwm_turn: cover property (pwm_on && tick1 && st.dir_down ##1 !st.dir_down);
  c_ctc: cover property (match_a && st.ctlb[CTB_CLEAR]);
endmodule
`default_nettype wire

// ### dual_timer_counter_prescaler_tb.sv
// Self-checking bench for the dual timer: registers, taps, pin counting, compare, capture, PWM.
// Assumes dtc_pkg and dtc_pin_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_prescaler_tb;
  import dtc_pkg::*;
  logic ref_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, go = 0, wide = 0, cap = 0, cmp = 0;
  logic [7:0] adr = 0, vack = 0, irq;
  logic [3:0] sel = 0, len = 1, gap = 1;
  logic [31:0] dat = 0, q, dat_o;
  logic ack, npin, wpin, pa, pa_on, pb, pb_on, busy, la, lb;
  int bad_count = 0, n_compared = 0, seed = 32'hcb3b;
  dtc_timer DUT (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .narrow_count_pin(npin), .wide_count_pin(wpin), .capture_pin(cap), .comparator_output(cmp),
    .vector_ack(vack), .timer_irq_req(irq), .compare_out_pin_a(pa), .compare_out_pin_a_connected(pa_on),
    .compare_out_pin_b(pb), .compare_out_pin_b_connected(pb_on));
  dtc_pin_model PM (.ref_clk(ref_clk), .rst(rst), .go(go), .wide(wide), .len(len), .gap(gap),
    .pin_a(pa), .pin_a_on(pa_on), .pin_b(pb), .pin_b_on(pb_on), .narrow_count_pin(npin),
    .wide_count_pin(wpin), .busy(busy), .line_a(la), .line_b(lb));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // The request is held until ack is sampled high; the write lands on that edge.
  task automatic wb(input logic w, input logic [5:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1; stb <= 1; we <= w; adr <= {idx, 2'b00}; dat <= d; sel <= 4'hF;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    q = dat_o;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task automatic burst(input logic w, input int n);
    @(posedge ref_clk);
    wide <= w; len <= n[3:0]; gap <= 4'h1 + 4'($unsigned($random(seed)) % 3); go <= 1;
    @(posedge ref_clk);
    go <= 0;
    repeat (2) @(posedge ref_clk);
    while (busy === 1'b1) @(posedge ref_clk);
    repeat (8) @(posedge ref_clk);
  endtask
  logic [5:0] regs[11] = '{IDX_WIDE_CTL_A, IDX_WIDE_CTL_B, IDX_WIDE_COUNT, IDX_CMP_A, IDX_CMP_B,
    IDX_CAPTURE, IDX_NARROW_CTL, IDX_NARROW_COUNT, IDX_FLAGS, IDX_MASK, IDX_CMP_CFG};
  logic [7:0] ctab[5] = '{8'h40, 8'h00, 8'hC0, 8'hC0, 8'h40};
  int wtab[5] = '{3, 3, 2, 8, 3};
  initial begin
    int n, v, exp, c, w;
    repeat (16) @(posedge ref_clk);
    rst <= 0;
    foreach (regs[i]) begin
      wb(0, regs[i], 0);
      check("reset value", q, 0);
    end
    check("pin a detached", {pa_on, la}, 2'b01);
    wb(1, IDX_WIDE_CTL_A, 32'hFF); wb(0, IDX_WIDE_CTL_A, 0); check("ctl a", q, 32'hF3);
    wb(1, IDX_WIDE_CTL_B, 32'hFF); wb(0, IDX_WIDE_CTL_B, 0); check("ctl b", q, 32'hCF);
    wb(1, IDX_NARROW_CTL, 32'hFF); wb(0, IDX_NARROW_CTL, 0); check("narrow ctl", q, 32'h07);
    wb(1, 6'h3F, 32'h5A); wb(0, 6'h3F, 0); check("unmapped", q, 0);
    wb(1, IDX_WIDE_CTL_A, 0); wb(1, IDX_WIDE_CTL_B, 0);
    // Taps: ticks between two cs writes equal span over divisor, give or take the phase.
    for (int t = 0; t < 4; t++) begin
      wb(1, IDX_NARROW_CTL, 0); wb(1, IDX_NARROW_COUNT, 0);
      wb(1, IDX_NARROW_CTL, CS_DIV8 + t);
      // The divisor exponents are 3, 6, 8 and 10, so the steps between taps are not even.
      repeat (4 << ((t == 0) ? 3 : 4 + 2 * t)) @(posedge ref_clk);
      wb(1, IDX_NARROW_CTL, 0); wb(0, IDX_NARROW_COUNT, 0);
      v = q;
      check("tap ticks", (v >= 3 && v <= 5), 1);
      repeat (30) @(posedge ref_clk);
      wb(0, IDX_NARROW_COUNT, 0); check("stopped", q, v);
    end
    // External pin counting, both counters, both edges, across the wrap.
    for (int i = 0; i < 4; i++) begin
      n = 1 + $unsigned($random(seed)) % 6;
      w = (i < 2);
      v = (w ? 32'h10000 : 32'h100) - 1 - $unsigned($random(seed)) % n;
      wb(1, w ? IDX_WIDE_CTL_B : IDX_NARROW_CTL, 0);
      wb(1, w ? IDX_WIDE_COUNT : IDX_NARROW_COUNT, v);
      wb(1, IDX_FLAGS, 32'hFF);
      wb(1, w ? IDX_WIDE_CTL_B : IDX_NARROW_CTL, CS_EXT_FALL + i[0]);
      burst(w[0], n);
      wb(1, w ? IDX_WIDE_CTL_B : IDX_NARROW_CTL, 0);
      wb(0, w ? IDX_WIDE_COUNT : IDX_NARROW_COUNT, 0);
      check("pin count", q, (v + n) & (w ? 32'hFFFF : 32'hFF));
      wb(0, IDX_FLAGS, 0);
      check("overflow", q[w ? FLG_OVF1 : FLG_OVF0], 1);
    end
    wb(1, IDX_MASK, FLAG_USED);
    // The mask lands at the ack edge, so the request line is looked at one edge later.
    @(posedge ref_clk);
    check("irq", irq[FLG_OVF0], 1);
    @(posedge ref_clk); vack <= 8'h02; @(posedge ref_clk); vack <= 0;
    wb(0, IDX_FLAGS, 0); check("vector clear", q[FLG_OVF0], 0);
    check("irq off", irq[FLG_OVF0], 0);
    // Compare channels with clear on A: one match each, pin action per mode.
    wb(1, IDX_CMP_A, 40); wb(1, IDX_CMP_B, 30);
    exp = 0;
    for (int m = 1; m < 5; m++) begin
      c = m & 3;
      wb(1, IDX_WIDE_CTL_B, 0); wb(1, IDX_WIDE_COUNT, 0);
      wb(1, IDX_WIDE_CTL_A, {c[1:0], c[1:0], 4'h0}); wb(1, IDX_FLAGS, 32'hFF);
      wb(1, IDX_WIDE_CTL_B, 32'h08 | CS_CK);
      n = 0;
      do begin
        wb(0, IDX_FLAGS, 0);
        n++;
      end while (q[FLG_CMPA] !== 1'b1 && n < 40);
      // The flags word must be judged before the next access replaces it.
      check("match flags", q[FLG_CMPB], 1);
      wb(1, IDX_WIDE_CTL_B, 0);
      // A detached pin shows its pull-up level on the line.
      exp = (c == 1) ? !exp : (c != 2);
      check("pin a", la, exp);
      check("pin b", lb, exp);
      wb(0, IDX_WIDE_COUNT, 0); check("cleared", q < 40, 1);
    end
    // Capture: counter parked at a known value, table of edge, filter and source.
    for (int i = 0; i < 5; i++) begin
      wb(1, IDX_CMP_CFG, i == 4); wb(1, IDX_WIDE_CTL_B, ctab[i]);
      @(posedge ref_clk); cap <= !ctab[i][CTB_EDGE]; cmp <= 0;
      repeat (10) @(posedge ref_clk);
      v = $unsigned($random(seed)) & 32'hFFFF;
      wb(1, IDX_WIDE_COUNT, v); wb(1, IDX_FLAGS, 32'hFF);
      @(posedge ref_clk);
      if (i == 4) cmp <= 1; else cap <= ctab[i][CTB_EDGE];
      repeat (wtab[i]) @(posedge ref_clk);
      cap <= !ctab[i][CTB_EDGE]; cmp <= 0;
      repeat (10) @(posedge ref_clk);
      wb(0, IDX_FLAGS, 0);
      check("capture flag", q[FLG_CAPT], i != 2);
      wb(0, IDX_CAPTURE, 0);
      if (i != 2) check("capture value", q, v);
    end
    // PWM: count stays within the selected top; mode 01 detaches the pin.
    for (int p = 1; p < 4; p++) begin
      wb(1, IDX_WIDE_CTL_A, {OM_TOGGLE, OM_CLEAR, 2'b00, p[1:0]});
      @(posedge ref_clk);
      check("pwm attach", {pa_on, pb_on}, 2'b01);
      wb(1, IDX_WIDE_CTL_B, CS_CK);
      repeat (6) begin
        repeat ($unsigned($random(seed)) % 700) @(posedge ref_clk);
        wb(0, IDX_WIDE_COUNT, 0);
        check("pwm range", q <= (32'h1 << (7 + p)) - 1, 1);
      end
    end
    stop_test();
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    stop_test();
  end
endmodule
`default_nettype wire
